// ==== design/tw_defines.svh ====
// Offsets, field positions, codes and reset values of the channel controller
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Register map, byte addresses
`define TW_CTRL_OFS      8'h00
`define TW_STAT_OFS      8'h04

// Control register fields
`define TW_CTRL_CHCLR_BIT  0
`define TW_CTRL_TCHK_BIT   1
`define TW_CTRL_TCHK_RST   1'b1

// Status register fields above the 12-bit status word
`define TW_STAT_CONN_BIT   12
`define TW_STAT_XERR_BIT   13
`define TW_STAT_FLOCK_BIT  14
`define TW_STAT_IRQ_BIT    15
`define TW_STAT_ABEN_BIT   16
`define TW_STAT_MANEN_BIT  17

// Status word bit positions (bit 0 rightmost)
`define TW_ST_READY_BIT    0
`define TW_ST_BUSY_BIT     1
`define TW_ST_UPPER_BIT    2
`define TW_ST_EOL_BIT      5
`define TW_ST_TPERR_BIT    10

// Function codes (octal 0001, 0002, 0004, 0010, 0020)
`define TW_FN_SEL_AB     12'h001
`define TW_FN_REL_AB     12'h002
`define TW_FN_CLR_IRQ    12'h004
`define TW_FN_SEL_MAN    12'h008
`define TW_FN_REL_MAN    12'h010

// Connect code: equipment number in top octal digit, rest zero
`define TW_CONN_EQ_HI    11
`define TW_CONN_EQ_LO    9
`define TW_CONN_REST     9'h000

// AXI responses
`define TW_RESP_OKAY     2'b00
`define TW_RESP_SLVERR   2'b10

`endif

// ==== design/tw_pkg.sv ====
// Types shared by the channel controller files
package tw_pkg;

   // Everything arriving from outside the clock domain
   typedef struct packed {
      logic [11:0] data;
      logic        par;
      logic        conn;
      logic        func;
      logic        wr;
      logic        chClr;
      logic        mClr;
      logic [2:0]  eqSw;
      logic        ready;
      logic        upper;
      logic        eol;
      logic        busy;
      logic        mismatch;
      logic        carrRet;
      logic        manSw;
   } pins_s;

   // Answers toward the data channel
   typedef struct packed {
      logic        reply;
      logic        reject;
      logic        parErr;
      logic [11:0] status;
      logic        statusPar;
      logic        statusValid;
      logic [7:0]  irqLines;
   } chan_out_s;

   // Characters passed on to the print mechanism
   typedef struct packed {
      logic [11:0] data;
      logic        valid;
   } char_out_s;

endpackage : tw_pkg

// ==== design/odd_parity.sv ====
// Odd parity generator and checker for a 12-bit channel word
`timescale 1ns/1ps
`default_nettype none

module odd_parity (
   input  wire logic [11:0] data,
   input  wire logic        parIn,
   output logic             parOut,
   output logic             parBad
);

   // Parity line is 1 when the data holds an even count of ones
   assign parOut = ~(^data);
   // Even total over data plus parity line means a lost or picked-up bit
   assign parBad = ~(^{data, parIn});

endmodule // odd_parity

`default_nettype wire

// ==== design/channel_irq_status_parity.sv ====
// Channel controller: interrupts, status word, transmission and type parity
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"

module channel_irq_status_parity (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire tw_pkg::pins_s     pinsIn,
   output var  tw_pkg::chan_out_s chanOut,
   output var  tw_pkg::char_out_s charOut,
   output logic                   connectInd,
   output logic                   xmsnParityInd,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   typedef struct packed {
      tw_pkg::pins_s     syncA;
      tw_pkg::pins_s     syncB;
      tw_pkg::pins_s     prev;
      logic              connected;
      logic              xmsnErr;
      logic              funcLock;
      logic              abEn;
      logic              manEn;
      logic              irq;
      logic              typeErr;
      logic              typeChk;
      tw_pkg::chan_out_s chOut;
      tw_pkg::char_out_s chr;
      logic              awHave;
      logic              wHave;
      logic [7:0]        awAddr;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } state_s;

   state_s s_reg;
   state_s s_next;

   logic        rxParBad;
   logic        stParOut;
   logic        unusedParBad;
   logic [11:0] statWord;

   // check incoming word against the parity line
   odd_parity rxCheck (
      .data   (s_reg.syncB.data),
      .parIn  (s_reg.syncB.par),
      .parOut (),
      .parBad (rxParBad)
   );

   // parity line for the status word sent back
   odd_parity stGen (
      .data   (statWord),
      .parIn  (1'b0),
      .parOut (stParOut),
      .parBad (unusedParBad)
   );

   // status word, sum of individual codes
   // bit positions counted from the right
   always_comb begin
      statWord = 12'h000;
      statWord[`TW_ST_READY_BIT] = s_reg.syncB.ready;
      statWord[`TW_ST_BUSY_BIT]  = s_reg.syncB.busy;
      statWord[`TW_ST_UPPER_BIT] = s_reg.syncB.upper;
      statWord[`TW_ST_EOL_BIT]   = s_reg.syncB.eol;
      statWord[`TW_ST_TPERR_BIT] = s_reg.typeErr;
   end

   always_comb begin
      logic        conE;
      logic        funE;
      logic        wrE;
      logic        mClr;
      logic        chClr;
      logic        eolE;
      logic        misE;
      logic        crE;
      logic        manE;
      logic        eqMatch;
      logic        irqSet;
      logic        irqClr;
      logic [31:0] rd;
      conE    = 1'b0;
      funE    = 1'b0;
      wrE     = 1'b0;
      mClr    = 1'b0;
      chClr   = 1'b0;
      eolE    = 1'b0;
      misE    = 1'b0;
      crE     = 1'b0;
      manE    = 1'b0;
      eqMatch = 1'b0;
      irqSet  = 1'b0;
      irqClr  = 1'b0;
      rd      = 32'h0000_0000;
      s_next  = s_reg;

      // Two-stage capture of everything from the pins
      s_next.syncA = pinsIn;
      s_next.syncB = s_reg.syncA;
      s_next.prev  = s_reg.syncB;

      // Edges from the second stage and its delayed copy only
      conE  = s_reg.syncB.conn & ~s_reg.prev.conn;
      funE  = s_reg.syncB.func & ~s_reg.prev.func;
      wrE   = s_reg.syncB.wr & ~s_reg.prev.wr;
      eolE  = s_reg.syncB.eol & ~s_reg.prev.eol;
      misE  = s_reg.syncB.mismatch & ~s_reg.prev.mismatch & s_reg.typeChk;
      crE   = s_reg.syncB.carrRet & ~s_reg.prev.carrRet;
      manE  = s_reg.syncB.manSw & ~s_reg.prev.manSw;
      mClr  = s_reg.syncB.mClr;
      chClr = s_reg.syncB.chClr;

      // One-cycle answers by default
      s_next.chOut.reply       = 1'b0;
      s_next.chOut.reject      = 1'b0;
      s_next.chOut.parErr      = 1'b0;
      s_next.chOut.statusValid = 1'b0;
      s_next.chr.valid         = 1'b0;
      s_next.chOut.status      = statWord;
      s_next.chOut.statusPar   = stParOut;

      // AXI4-Lite write side: address and data in either order
      if (s_reg.awready && s_axi_awvalid) begin
         s_next.awHave = 1'b1;
         s_next.awAddr = s_axi_awaddr;
      end
      if (s_reg.wready && s_axi_wvalid) begin
         s_next.wHave = 1'b1;
         s_next.wData = s_axi_wdata;
         s_next.wStrb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.awHave && s_reg.wHave && !s_reg.bvalid) begin
         s_next.awHave = 1'b0;
         s_next.wHave  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = `TW_RESP_OKAY;
         if (s_reg.awAddr == `TW_CTRL_OFS) begin
            if (s_reg.wStrb[0]) begin
               chClr = chClr | s_reg.wData[`TW_CTRL_CHCLR_BIT];
               s_next.typeChk = s_reg.wData[`TW_CTRL_TCHK_BIT];
            end
         end else if (s_reg.awAddr == `TW_STAT_OFS) begin
            // Read-only, write ignored
            s_next.bresp = `TW_RESP_OKAY;
         end else begin
            s_next.bresp = `TW_RESP_SLVERR;
         end
      end
      s_next.awready = ~s_next.awHave & ~s_next.bvalid;
      s_next.wready  = ~s_next.wHave & ~s_next.bvalid;

      // AXI4-Lite read side
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_reg.arready && s_axi_arvalid) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = `TW_RESP_OKAY;
         if (s_axi_araddr == `TW_CTRL_OFS) begin
            rd[`TW_CTRL_TCHK_BIT] = s_reg.typeChk;
         end else if (s_axi_araddr == `TW_STAT_OFS) begin
            rd[11:0]                = statWord;
            rd[`TW_STAT_CONN_BIT]   = s_reg.connected;
            rd[`TW_STAT_XERR_BIT]   = s_reg.xmsnErr;
            rd[`TW_STAT_FLOCK_BIT]  = s_reg.funcLock;
            rd[`TW_STAT_IRQ_BIT]    = s_reg.irq;
            rd[`TW_STAT_ABEN_BIT]   = s_reg.abEn;
            rd[`TW_STAT_MANEN_BIT]  = s_reg.manEn;
         end else begin
            s_next.rresp = `TW_RESP_SLVERR;
         end
         s_next.rdata = rd;
      end
      s_next.arready = ~s_next.rvalid;

      // Connect code handling
      // top octal digit must equal the switch, remainder zero
      eqMatch = (s_reg.syncB.data[`TW_CONN_EQ_HI:`TW_CONN_EQ_LO] == s_reg.syncB.eqSw) &&
                (s_reg.syncB.data[`TW_CONN_EQ_LO-1:0] == `TW_CONN_REST);
      if (conE) begin
         if (rxParBad) begin
            // no connect, no reply, drop any connection, flag error
            s_next.connected = 1'b0;
            s_next.xmsnErr   = 1'b1;
         end else if (s_reg.xmsnErr) begin
            // refused while error stands; status still shown if the code matches
            // status presented on a refused connect attempt only when the code matches the switch
            s_next.connected         = 1'b0;
            s_next.chOut.statusValid = eqMatch;
         end else if (eqMatch) begin
            s_next.connected         = 1'b1;
            s_next.funcLock          = 1'b0;
            s_next.chOut.reply       = 1'b1;
            s_next.chOut.statusValid = 1'b1;
         end else begin
            s_next.connected = 1'b0;
         end
      end

      // Function code handling, only when connected
      if (funE && s_reg.connected) begin
         if (rxParBad) begin
            // skip, no reply or reject, parity error back, flag it
            s_next.chOut.parErr = 1'b1;
            s_next.xmsnErr      = 1'b1;
            s_next.funcLock     = 1'b1;
         end else if (!s_reg.funcLock) begin
            s_next.chOut.reply = 1'b1;
            // abnormal-end and manual select and release, and clear interrupt
            if (s_reg.syncB.data == `TW_FN_SEL_AB) begin
               s_next.abEn = 1'b1;
               irqClr      = 1'b1;
            end else if (s_reg.syncB.data == `TW_FN_REL_AB) begin
               s_next.abEn = 1'b0;
            end else if (s_reg.syncB.data == `TW_FN_CLR_IRQ) begin
               irqClr = 1'b1;
            end else if (s_reg.syncB.data == `TW_FN_SEL_MAN) begin
               s_next.manEn = 1'b1;
               irqClr       = 1'b1;
            end else if (s_reg.syncB.data == `TW_FN_REL_MAN) begin
               s_next.manEn = 1'b0;
            end else begin
               s_next.chOut.reply  = 1'b0;
               s_next.chOut.reject = 1'b1;
            end
         end
      end

      // Write data, only when connected: character passed on, even when faulty
      if (wrE && s_reg.connected) begin
         // reply plus parity error, flag, still type
         s_next.chr.data    = s_reg.syncB.data;
         s_next.chr.valid   = 1'b1;
         s_next.chOut.reply = 1'b1;
         if (rxParBad) begin
            s_next.chOut.parErr = 1'b1;
            s_next.xmsnErr      = 1'b1;
         end
      end

      // error flag cleared only by channel or master clear
      if ((chClr || mClr) && !(s_next.xmsnErr && !s_reg.xmsnErr)) begin
         s_next.xmsnErr = 1'b0;
      end

      // type parity status, set wins over carrier return
      if (misE) begin
         s_next.typeErr = 1'b1;
      end else if (crE) begin
         s_next.typeErr = 1'b0;
      end

      // selected group with an event raises the interrupt
      // end of line counts as abnormal end
      // manual switch works connected or not
      irqSet = (s_reg.abEn & (eolE | misE)) | (s_reg.manEn & manE);
      // holds until reselect, clear code or master clear; a new event wins over the codes
      if (irqSet) begin
         s_next.irq = 1'b1;
      end else if (irqClr) begin
         s_next.irq = 1'b0;
      end

      // Master clear acts like reset on control state
      if (mClr) begin
         s_next.connected = 1'b0;
         s_next.funcLock  = 1'b0;
         s_next.abEn      = 1'b0;
         s_next.manEn     = 1'b0;
         s_next.irq       = 1'b0;
         s_next.typeErr   = 1'b0;
      end

      // always driven on the attached channel
      // line selected by the equipment number
      s_next.chOut.irqLines = 8'h00;
      s_next.chOut.irqLines[s_reg.syncB.eqSw] = s_next.irq;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg         <= '0;
         s_reg.typeChk <= `TW_CTRL_TCHK_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign chanOut       = s_reg.chOut;
   assign charOut       = s_reg.chr;
   assign connectInd    = s_reg.connected;
   assign xmsnParityInd = s_reg.xmsnErr;
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready  = s_reg.wready;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rdata   = s_reg.rdata;
   assign s_axi_rresp   = s_reg.rresp;

endmodule // channel_irq_status_parity

`default_nettype wire

// ==== test/chan_ctrl_props.sv ====
// Concurrent checks on the channel controller ports
`timescale 1ns/1ps
`default_nettype none

module chan_ctrl_props (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire tw_pkg::pins_s     pinsIn,
   input wire tw_pkg::chan_out_s chanOut,
   input wire tw_pkg::char_out_s charOut,
   input wire logic              connectInd,
   input wire logic              xmsnParityInd
);
   logic [5:0] clrHist;
   logic [5:0] evHist;
   logic       parOk;

   assign parOk = ^{pinsIn.data, pinsIn.par};

   // Recent causes, so interrupt edges can be traced back
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clrHist <= '0;
         evHist  <= '0;
      end else begin
         clrHist <= {clrHist[4:0], pinsIn.func | pinsIn.mClr};
         evHist  <= {evHist[4:0], pinsIn.eol | pinsIn.mismatch | pinsIn.manSw};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence connMatch;
      $rose(pinsIn.conn) && parOk && !xmsnParityInd && pinsIn.data == {pinsIn.eqSw, 9'h000};
   endsequence
   sequence connBad;
      $rose(pinsIn.conn) && !parOk;
   endsequence
   sequence funcBad;
      $rose(pinsIn.func) && !parOk && connectInd;
   endsequence
   sequence silent6;
      (!chanOut.reply && !chanOut.reject) [*6];
   endsequence

   a_good_connect: assert property (connMatch |-> ##[3:5]
      (chanOut.reply && chanOut.statusValid && connectInd)) else $error("connect not answered");
   a_conn_parity: assert property (connBad |-> ##1 silent6 ##1
      (xmsnParityInd && !connectInd)) else $error("bad connect answered");
   a_func_parity: assert property (funcBad |-> ##1 silent6)
      else $error("bad function answered");
   a_write_parity: assert property ($rose(pinsIn.wr) && !parOk && connectInd |-> ##[3:5]
      (chanOut.reply && chanOut.parErr && charOut.valid)) else $error("bad write not flagged");
   a_irq_line: assert property ((chanOut.irqLines & ~(8'h01 << pinsIn.eqSw)) == 8'h00)
      else $error("interrupt on wrong line");
   a_irq_hold: assert property ($fell(|chanOut.irqLines) |-> |clrHist)
      else $error("interrupt dropped without clear");
   a_irq_cause: assert property ($rose(|chanOut.irqLines) |-> |evHist)
      else $error("interrupt without event");
   a_status_word: assert property ($stable({pinsIn.eol, pinsIn.upper, pinsIn.busy,
      pinsIn.ready}) [*6] |-> chanOut.status[5:0] == {pinsIn.eol, 2'b00, pinsIn.upper,
      pinsIn.busy, pinsIn.ready}) else $error("status word wrong");
   a_status_par: assert property ($stable(chanOut.status) [*2] |->
      chanOut.statusPar == ~^chanOut.status) else $error("status parity wrong");
   a_type_err: assert property ($rose(pinsIn.mismatch) && !pinsIn.carrRet |-> ##[2:5]
      chanOut.status[10]) else $error("type error not shown");
endmodule // chan_ctrl_props

bind channel_irq_status_parity chan_ctrl_props props (.clk(clk), .sys_rst(sys_rst),
   .pinsIn(pinsIn), .chanOut(chanOut), .charOut(charOut), .connectInd(connectInd),
   .xmsnParityInd(xmsnParityInd));

`default_nettype wire

// ==== test/chan_host_model.sv ====
// Host data channel model sending connect, function and write codes
`timescale 1ns/1ps
`default_nettype none

module chan_host_model #(
   parameter int TO_CYC = 4000
) (
   input  wire logic              clk,
   input  wire tw_pkg::chan_out_s chanOut,
   input  wire tw_pkg::char_out_s charOut,
   output logic [11:0]            data,
   output logic                   par,
   output logic [2:0]             strobe
);
   logic [4:0]  obs;
   logic [11:0] chr;
   logic        intRej;
   logic        ioParErr;

   initial begin
      data = 12'h555;
      par = 1'b0;
      strobe = 3'b000;
      ioParErr = 1'b0;
   end

   // Seen pulses, as {reply, reject, parErr, statusValid, charValid}
   task automatic sample();
      obs = obs | {chanOut.reply, chanOut.reject, chanOut.parErr, chanOut.statusValid,
         charOut.valid};
      if (charOut.valid) chr = charOut.data;
      if (chanOut.parErr) ioParErr = 1'b1;
   endtask

   task automatic clrIo();
      ioParErr = 1'b0;
   endtask

   // Data settles four cycles before the strobe and outlasts it
   task automatic xfer(input int kind, input logic [11:0] w, input logic bad);
      int k;
      obs = '0;
      @(posedge clk);
      data <= w;
      par <= (~^w) ^ bad;
      repeat (4) @(posedge clk);
      strobe[kind] <= 1'b1;
      for (k = 0; k < TO_CYC && !(obs[4] || obs[3]); k++) begin
         @(posedge clk);
         sample();
      end
      intRej = !(obs[4] || obs[3]);
      repeat (5) begin
         @(posedge clk);
         strobe <= 3'b000;
         sample();
      end
      // Released lines show the inverse, never the last value
      data <= ~w;
      par <= (~^w) ^ ~bad;
   endtask
endmodule // chan_host_model

`default_nettype wire

// ==== test/test_channel_irq_status_parity.sv ====
// Self-checking bench for the channel controller
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"

module test_channel_irq_status_parity;
   logic              clk, sys_rst;
   tw_pkg::pins_s     u, pins;
   tw_pkg::chan_out_s chanOut;
   tw_pkg::char_out_s charOut;
   logic              connectInd, xmsnParityInd, hPar;
   logic [11:0]       hData, st, cc;
   logic [2:0]        hStb;
   logic [7:0]        awaddr, araddr, irqBit;
   logic [31:0]       wdata, rdata, d;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, resp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   integer            seed, errTotal, nTests;

   always_comb begin
      pins = u;
      pins.data = hData;
      pins.par = hPar;
      pins.conn = hStb[0];
      pins.func = hStb[1];
      pins.wr = hStb[2];
   end

   channel_irq_status_parity dut (.clk(clk), .sys_rst(sys_rst), .pinsIn(pins),
      .chanOut(chanOut), .charOut(charOut), .connectInd(connectInd),
      .xmsnParityInd(xmsnParityInd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   chan_host_model host (.clk(clk), .chanOut(chanOut), .charOut(charOut), .data(hData),
      .par(hPar), .strobe(hStb));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chkW(input string n, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         errTotal++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkB(input string n, input logic e, input logic g);
      nTests++;
      if (g !== e) begin
         errTotal++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask

   // No cycle limit here: only the watchdog ends a hung handshake
   task automatic axiWr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, v, 4'h1};
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axiRd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      {d, resp} = {rdata, rresp};
      rready <= 1'b0;
   endtask

   // Flags {manEn, abEn, irq, funcLock, xmsnErr, connected}
   task automatic chkStat(input logic [5:0] e);
      axiRd(`TW_STAT_OFS);
      chkW("stat", {26'h0, e}, {26'h0, d[17:12]});
   endtask
   task automatic xc(input int kind, input logic [11:0] w, input logic bad, input logic [4:0] e);
      host.xfer(kind, w, bad);
      chkW("answers", {27'h0, e}, {27'h0, host.obs});
   endtask
   task automatic chkIrq(input logic [7:0] e);
      chkW("irq", {24'h0, e}, {24'h0, chanOut.irqLines});
   endtask
   // Pulses {mClr, chClr, manSw, carrRet, mismatch}
   task automatic hit(input logic [4:0] sel);
      @(posedge clk);
      {u.mClr, u.chClr, u.manSw, u.carrRet, u.mismatch} <= sel;
      repeat (3) @(posedge clk);
      {u.mClr, u.chClr, u.manSw, u.carrRet, u.mismatch} <= 5'h00;
      repeat (8) @(posedge clk);
   endtask

   initial begin
      #1_500_000;
      errTotal++;
      summarize();
   end

   initial begin
      {seed, errTotal, nTests} = {32'd68668, 32'd0, 32'd0};
      sys_rst = 1'b1;
      u = '0;
      u.eqSw = 3'($random(seed));
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      irqBit = 8'h01 << u.eqSw;
      cc = {u.eqSw, `TW_CONN_REST};
      repeat (4) @(posedge clk);
      repeat (4) begin
         st = 12'($random(seed)) & 12'h027;
         @(posedge clk);
         {u.eol, u.upper, u.busy, u.ready} <= {st[5], st[2:0]};
         repeat (6) @(posedge clk);
         chkW("status", {20'h0, st}, {20'h0, chanOut.status});
         chkB("statusPar", ~^st, chanOut.statusPar);
      end
      axiRd(`TW_STAT_OFS);
      chkW("statWord", {20'h0, st}, {20'h0, d[11:0]});
      u.eol <= 1'b0;
      axiRd(8'h08);
      chkW("rresp", {30'h0, `TW_RESP_SLVERR}, {30'h0, resp});
      chkW("rdata", 32'h0000_0000, d);
      axiWr(8'h0C, 32'hFFFF_FFFF);
      chkW("bresp", {30'h0, `TW_RESP_SLVERR}, {30'h0, resp});
      xc(0, {u.eqSw + 3'h1, 9'h000}, 1'b0, 5'b00000);
      chkB("intRej", 1'b1, host.intRej);
      xc(0, cc, 1'b0, 5'b10010);
      xc(1, `TW_FN_SEL_AB, 1'b0, 5'b10000);
      chkStat(6'b010001);
      u.eol <= 1'b1;
      repeat (8) @(posedge clk);
      chkIrq(irqBit);
      repeat (40) @(posedge clk);
      chkIrq(irqBit);
      xc(1, `TW_FN_CLR_IRQ, 1'b0, 5'b10000);
      chkIrq(8'h00);
      hit(5'b00001);
      chkIrq(irqBit);
      chkB("typeErr", 1'b1, chanOut.status[`TW_ST_TPERR_BIT]);
      xc(1, `TW_FN_SEL_AB, 1'b0, 5'b10000);
      chkIrq(8'h00);
      hit(5'b00010);
      chkB("typeErr", 1'b0, chanOut.status[`TW_ST_TPERR_BIT]);
      xc(1, `TW_FN_SEL_MAN, 1'b0, 5'b10000);
      hit(5'b00100);
      chkIrq(irqBit);
      xc(1, `TW_FN_REL_MAN, 1'b0, 5'b10000);
      xc(1, `TW_FN_REL_AB, 1'b0, 5'b10000);
      chkStat(6'b001001);
      xc(1, `TW_FN_CLR_IRQ, 1'b0, 5'b10000);
      u.eol <= 1'b0;
      hit(5'b00001);
      chkIrq(8'h00);
      xc(1, 12'h040, 1'b0, 5'b01000);
      xc(2, 12'h3A5, 1'b1, 5'b10101);
      chkW("char", 32'h0000_03A5, {20'h0, host.chr});
      chkB("xmsn", 1'b1, xmsnParityInd);
      chkB("ioParErr", 1'b1, host.ioParErr);
      axiWr(`TW_CTRL_OFS, 32'h0000_0003);
      chkW("bresp", {30'h0, `TW_RESP_OKAY}, {30'h0, resp});
      host.clrIo();
      repeat (2) @(posedge clk);
      chkB("xmsn", 1'b0, xmsnParityInd);
      axiRd(`TW_CTRL_OFS);
      chkW("ctrl", 32'h0000_0002, d);
      chkW("rresp", {30'h0, `TW_RESP_OKAY}, {30'h0, resp});
      xc(0, cc, 1'b0, 5'b10010);
      st = 12'($random(seed));
      xc(2, st, 1'b0, 5'b10001);
      chkW("char", {20'h0, st}, {20'h0, host.chr});
      xc(1, `TW_FN_SEL_MAN, 1'b1, 5'b00100);
      chkB("intRej", 1'b1, host.intRej);
      chkStat(6'b000111);
      hit(5'b01000);
      chkB("xmsn", 1'b0, xmsnParityInd);
      xc(1, `TW_FN_SEL_MAN, 1'b0, 5'b00000);
      xc(0, cc, 1'b0, 5'b10010);
      xc(1, `TW_FN_SEL_MAN, 1'b0, 5'b10000);
      xc(0, cc, 1'b1, 5'b00000);
      chkB("connect", 1'b0, connectInd);
      xc(0, cc, 1'b0, 5'b00010);
      chkB("connect", 1'b0, connectInd);
      hit(5'b00100);
      chkIrq(irqBit);
      hit(5'b10000);
      chkIrq(8'h00);
      chkStat(6'b000000);
      xc(0, cc, 1'b0, 5'b10010);
      summarize();
   end
endmodule // test_channel_irq_status_parity

`default_nettype wire
